// ---- rtl/half_bridge_driver_ctrl.sv ----
// Primary-side control of a dual-channel half-bridge gate driver: modes, interlock and converter reactions.
`timescale 1ns/100ps
`default_nettype none

module half_bridge_driver_ctrl (
  input  wire logic                                clock,
  input  wire logic                                rst_b,
  input  wire logic                                suppliesGood,
  input  wire hb_ctrl_pkg::mode_in_t               modeBottom,
  input  wire hb_ctrl_pkg::mode_in_t               modeTop,
  input  wire logic                                gate_cmd_bottom,
  input  wire logic                                gate_cmd_top,
  input  wire hb_ctrl_pkg::conv_sense_t            senseBottom,
  input  wire hb_ctrl_pkg::conv_sense_t            senseTop,
  output var  logic                                gateBottom,
  output var  logic                                gateTop,
  output var  logic                                convRunBottom,
  output var  logic                                convRunTop,
  output var  logic                                dischargeBottom,
  output var  logic                                dischargeTop,
  output var  logic                                operating,
  output var  logic [hb_ctrl_pkg::DIAG_W-1:0]      diagBottom,
  output var  logic [hb_ctrl_pkg::DIAG_W-1:0]      diagTop
);

  // Synchroniser stages: first stage feeds only the second.
  logic [5:0] syncMeta;
  logic [5:0] syncIn;
  logic [5:0] rawIn;
  hb_ctrl_pkg::mode_t modeB;
  hb_ctrl_pkg::mode_t modeT;
  logic cmdB;
  logic cmdT;

  assign rawIn = {modeBottom.modeEnable, modeBottom.modeSelect, modeTop.modeEnable,
                  modeTop.modeSelect, gate_cmd_bottom, gate_cmd_top};

  // Two flops per input so a mode change is decoded from a clean level.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      syncMeta <= 6'h00;
      syncIn   <= 6'h00;
    end else begin
      syncMeta <= rawIn;
      syncIn   <= syncMeta;
    end
  end

  // Mode decode from enable and select.
  function automatic hb_ctrl_pkg::mode_t decodeMode(input logic en, input logic sel);
    hb_ctrl_pkg::mode_t m;
    case ({en, sel})
      2'b00:   m = hb_ctrl_pkg::MODE_NORMAL;
      2'b10:   m = hb_ctrl_pkg::MODE_SHORT_OFF;
      2'b11:   m = hb_ctrl_pkg::MODE_SHORT_ON;
      2'b01:   m = hb_ctrl_pkg::MODE_DISCHARGE;
      default: m = hb_ctrl_pkg::MODE_NORMAL;
    endcase
    return m;
  endfunction : decodeMode

  assign modeB = decodeMode(syncIn[5], syncIn[4]);
  assign modeT = decodeMode(syncIn[3], syncIn[2]);
  assign cmdB  = syncIn[1];
  assign cmdT  = syncIn[0];

  // Start-up sequencer: waits the delay, then a converter start-up phase, then stable.
  hb_ctrl_pkg::phase_t phase;
  hb_ctrl_pkg::phase_t next_phase;
  logic [hb_ctrl_pkg::CNT_W-1:0] count;
  logic [hb_ctrl_pkg::CNT_W-1:0] next_count;

  always_comb begin
    next_phase = phase;
    next_count = count;
    case (phase)
      hb_ctrl_pkg::ST_WAIT: begin
        if (!suppliesGood) begin
          next_count = '0;
        end else if (count == hb_ctrl_pkg::CNT_W'(hb_ctrl_pkg::STARTUP_CYCLES - 1)) begin
          next_phase = hb_ctrl_pkg::ST_START;
          next_count = '0;
        end else begin
          next_count = count + 1'b1;
        end
      end
      hb_ctrl_pkg::ST_START: begin
        if (count == hb_ctrl_pkg::CNT_W'(hb_ctrl_pkg::CONV_START_CYCLES - 1)) begin
          next_phase = hb_ctrl_pkg::ST_STABLE;
          next_count = '0;
        end else begin
          next_count = count + 1'b1;
        end
      end
      hb_ctrl_pkg::ST_STABLE: begin
        next_count = '0;
      end
      default: begin
        next_phase = hb_ctrl_pkg::ST_WAIT;
        next_count = '0;
      end
    endcase
    // Losing supply restarts the whole sequence.
    if (!suppliesGood) begin
      next_phase = hb_ctrl_pkg::ST_WAIT;
      next_count = '0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      phase <= hb_ctrl_pkg::ST_WAIT;
      count <= '0;
    end else begin
      phase <= next_phase;
      count <= next_count;
    end
  end

  logic active;
  logic inStart;
  assign active  = (phase != hb_ctrl_pkg::ST_WAIT);
  assign inStart = (phase == hb_ctrl_pkg::ST_START);

  // Gate path: shared interlock unless either channel is discharging, then mode override.
  logic discB;
  logic discT;
  logic bothOn;
  logic interlockHit;
  logic next_gateB;
  logic next_gateT;

  always_comb begin
    discB        = (modeB == hb_ctrl_pkg::MODE_DISCHARGE);
    discT        = (modeT == hb_ctrl_pkg::MODE_DISCHARGE);
    bothOn       = cmdB && cmdT;
    // Interlock is only armed when neither side is discharging, since a lock needs both ends.
    interlockHit = active && bothOn && !discB && !discT;
    next_gateB   = active && cmdB && !interlockHit;
    next_gateT   = active && cmdT && !interlockHit;
    if (active && modeB == hb_ctrl_pkg::MODE_SHORT_OFF) next_gateB = 1'b0;
    if (active && modeB == hb_ctrl_pkg::MODE_SHORT_ON)  next_gateB = 1'b1;
    if (active && modeT == hb_ctrl_pkg::MODE_SHORT_OFF) next_gateT = 1'b0;
    if (active && modeT == hb_ctrl_pkg::MODE_SHORT_ON)  next_gateT = 1'b1;
  end

  // Converter reaction per channel from its sensors and the current phase.
  logic ocB;
  logic ocT;
  logic next_runB;
  logic next_runT;
  logic [hb_ctrl_pkg::DIAG_W-1:0] next_diagB;
  logic [hb_ctrl_pkg::DIAG_W-1:0] next_diagT;

  always_comb begin
    ocB = senseBottom.overcurrentA || senseBottom.overcurrentB;
    ocT = senseTop.overcurrentA || senseTop.overcurrentB;
    // Level two stops in any phase; overcurrent only during start-up; level one never stops.
    next_runB = active && !senseBottom.tempWarn2 && !(inStart && ocB);
    next_runT = active && !senseTop.tempWarn2 && !(inStart && ocT);
    // Flags are recomputed every cycle, so each returns high once its cause is gone.
    next_diagB = hb_ctrl_pkg::DIAG_RESET;
    next_diagT = hb_ctrl_pkg::DIAG_RESET;
    if (active) begin
      next_diagB[hb_ctrl_pkg::BIT_TEMP1] = !(senseBottom.tempWarn1 || senseBottom.tempWarn2);
      next_diagB[hb_ctrl_pkg::BIT_TEMP2] = !senseBottom.tempWarn2;
      next_diagB[hb_ctrl_pkg::BIT_OVERCURRENT] = !ocB;
      next_diagB[hb_ctrl_pkg::BIT_INTERLOCK] = !interlockHit;
      next_diagT[hb_ctrl_pkg::BIT_TEMP1] = !(senseTop.tempWarn1 || senseTop.tempWarn2);
      next_diagT[hb_ctrl_pkg::BIT_TEMP2] = !senseTop.tempWarn2;
      next_diagT[hb_ctrl_pkg::BIT_OVERCURRENT] = !ocT;
      next_diagT[hb_ctrl_pkg::BIT_INTERLOCK] = !interlockHit;
    end
  end

  // Output registers.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gateBottom      <= 1'b0;
      gateTop         <= 1'b0;
      convRunBottom   <= 1'b0;
      convRunTop      <= 1'b0;
      dischargeBottom <= 1'b0;
      dischargeTop    <= 1'b0;
      operating       <= 1'b0;
      diagBottom      <= hb_ctrl_pkg::DIAG_RESET;
      diagTop         <= hb_ctrl_pkg::DIAG_RESET;
    end else begin
      gateBottom      <= next_gateB;
      gateTop         <= next_gateT;
      convRunBottom   <= next_runB;
      convRunTop      <= next_runT;
      dischargeBottom <= active && discB;
      dischargeTop    <= active && discT;
      operating       <= active;
      diagBottom      <= next_diagB;
      diagTop         <= next_diagT;
    end
  end

  // Assertions next to the logic they guard.
  a_gate_never_both: assert property (@(posedge clock) disable iff (!rst_b)
    (gateBottom && gateTop) |-> ($past(modeB) != hb_ctrl_pkg::MODE_NORMAL || $past(modeT) != hb_ctrl_pkg::MODE_NORMAL))
    else $error("Both gates on in normal mode.");
  a_interlock_flag: assert property (@(posedge clock) disable iff (!rst_b)
    (active && cmdB && cmdT && !discB && !discT) |=> (!diagBottom[28] && !diagTop[28]))
    else $error("Interlock flag not lowered.");
  a_short_on_hold: assert property (@(posedge clock) disable iff (!rst_b)
    (active && modeB == hb_ctrl_pkg::MODE_SHORT_ON) |=> gateBottom)
    else $error("Forced-on bottom gate not on.");
  a_short_off_hold: assert property (@(posedge clock) disable iff (!rst_b)
    (active && modeT == hb_ctrl_pkg::MODE_SHORT_OFF) |=> !gateTop)
    else $error("Forced-off top gate not off.");
  a_temp2_stops: assert property (@(posedge clock) disable iff (!rst_b)
    (active && senseBottom.tempWarn2) |=> (!convRunBottom && !diagBottom[23] && !diagBottom[24]))
    else $error("Level two temperature reaction wrong.");
  a_temp1_runs: assert property (@(posedge clock) disable iff (!rst_b)
    (active && senseTop.tempWarn1 && !senseTop.tempWarn2 && !ocT) |=> (convRunTop && !diagTop[23] && diagTop[24]))
    else $error("Level one temperature reaction wrong.");
  a_oc_startup: assert property (@(posedge clock) disable iff (!rst_b)
    (inStart && ocB) |=> (!convRunBottom && !diagBottom[25]))
    else $error("Start-up overcurrent did not stop converter.");
  a_oc_stable: assert property (@(posedge clock) disable iff (!rst_b)
    (phase == hb_ctrl_pkg::ST_STABLE && ocT && !senseTop.tempWarn2) |=> (convRunTop && !diagTop[25]))
    else $error("Stable overcurrent reaction wrong.");
  a_flag_recovers: assert property (@(posedge clock) disable iff (!rst_b)
    (!ocB ##1 !ocB) |=> diagBottom[25])
    else $error("Overcurrent flag did not return high.");
  a_wait_idle: assert property (@(posedge clock) disable iff (!rst_b)
    (phase == hb_ctrl_pkg::ST_WAIT) |=> (!gateBottom && !gateTop && !operating))
    else $error("Activity before start-up delay.");
  a_sync_latency: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(gate_cmd_top) ##1 gate_cmd_top |=> cmdT)
    else $error("Synchroniser latency wrong.");

  c_stable_reached: cover property (@(posedge clock) disable iff (!rst_b) phase == hb_ctrl_pkg::ST_STABLE);
  c_interlock_event: cover property (@(posedge clock) disable iff (!rst_b) !diagBottom[28]);
  c_discharge_both: cover property (@(posedge clock) disable iff (!rst_b) dischargeBottom && gateBottom && gateTop);
  c_short_on: cover property (@(posedge clock) disable iff (!rst_b) active && modeT == hb_ctrl_pkg::MODE_SHORT_ON);

endmodule : half_bridge_driver_ctrl

`default_nettype wire

// ---- rtl/hb_ctrl_pkg.sv ----
// Package with modes, diagnostic bit positions, timing constants and carrier types of the half-bridge control.
package hb_ctrl_pkg;

  // Mode decode of the two mode-select inputs.
  typedef enum logic [1:0] {
    MODE_NORMAL    = 2'b00,
    MODE_SHORT_OFF = 2'b01,
    MODE_SHORT_ON  = 2'b10,
    MODE_DISCHARGE = 2'b11
  } mode_t;

  // Start-up sequencer states.
  typedef enum logic [1:0] {
    ST_WAIT   = 2'b00,
    ST_START  = 2'b01,
    ST_STABLE = 2'b10
  } phase_t;

  // Diagnostic bit positions inside the bitstream word.
  localparam int DIAG_W          = 29;
  localparam int BIT_TEMP1       = 23;
  localparam int BIT_TEMP2       = 24;
  localparam int BIT_OVERCURRENT = 25;
  localparam int BIT_INTERLOCK   = 28;

  // Timing: clock period and start-up delay, both in nanoseconds.
  localparam int CLK_PERIOD_NS    = 8;
  localparam int STARTUP_DELAY_NS = 10000;
  localparam int STARTUP_CYCLES   = (STARTUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Converter start-up phase length in cycles after the delay expires.
  localparam int CONV_START_NS     = 2000;
  localparam int CONV_START_CYCLES = (CONV_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W             = 16;

  // Reset values.
  localparam logic [DIAG_W-1:0] DIAG_RESET = {DIAG_W{1'b1}};

  // Sensor inputs of one channel.
  typedef struct packed {
    logic tempWarn1;
    logic tempWarn2;
    logic overcurrentA;
    logic overcurrentB;
  } conv_sense_t;

  // Mode inputs of one channel.
  typedef struct packed {
    logic modeEnable;
    logic modeSelect;
  } mode_in_t;

endpackage : hb_ctrl_pkg

// ---- verif/half_bridge_driver_ctrl_test.sv ----
// Self-checking testbench of the half-bridge control: modes, interlock, start-up and converter flags.
`timescale 1ns/100ps
`default_nettype none

module half_bridge_driver_ctrl_test;
  typedef struct packed {
    logic [1:0] modeB;
    logic [1:0] modeT;
    logic       cmdB;
    logic       cmdT;
    logic [3:0] sense;
    logic       gB;
    logic       gT;
    logic       ilk;
    logic       dis;
  } row_t;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic suppliesGood = 1'b0;
  hb_ctrl_pkg::mode_in_t wModeB = '0, wModeT = '0, modeBottom, modeTop;
  logic wCmdB = 1'b0, wCmdT = 1'b0, cmdB, cmdT;
  hb_ctrl_pkg::conv_sense_t senseBottom = '0, senseTop = '0;
  logic gateBottom, gateTop, convRunBottom, convRunTop, dischargeBottom, dischargeTop, operating;
  logic [hb_ctrl_pkg::DIAG_W-1:0] diagBottom, diagTop, expd;
  int n_fail = 0;
  int num_checks = 0;
  row_t r;
  row_t rows [15] = '{
    '{2'h0, 2'h0, 1'b1, 1'b0, 4'h0, 1'b1, 1'b0, 1'b0, 1'b0},
    '{2'h0, 2'h0, 1'b0, 1'b1, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0},
    '{2'h0, 2'h0, 1'b1, 1'b1, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0},
    '{2'h1, 2'h0, 1'b1, 1'b1, 4'h0, 1'b1, 1'b1, 1'b0, 1'b1},
    '{2'h2, 2'h0, 1'b1, 1'b0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0},
    '{2'h3, 2'h0, 1'b0, 1'b0, 4'h0, 1'b1, 1'b0, 1'b0, 1'b0},
    '{2'h0, 2'h1, 1'b1, 1'b1, 4'h0, 1'b1, 1'b1, 1'b0, 1'b0},
    '{2'h3, 2'h2, 1'b0, 1'b1, 4'h0, 1'b1, 1'b0, 1'b0, 1'b0},
    '{2'h0, 2'h3, 1'b0, 1'b0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0},
    '{2'h0, 2'h0, 1'b0, 1'b0, 4'h8, 1'b0, 1'b0, 1'b0, 1'b0},
    '{2'h0, 2'h0, 1'b0, 1'b0, 4'h4, 1'b0, 1'b0, 1'b0, 1'b0},
    '{2'h0, 2'h0, 1'b0, 1'b0, 4'h2, 1'b0, 1'b0, 1'b0, 1'b0},
    '{2'h0, 2'h0, 1'b0, 1'b0, 4'h9, 1'b0, 1'b0, 1'b0, 1'b0},
    '{2'h0, 2'h0, 1'b0, 1'b0, 4'h6, 1'b0, 1'b0, 1'b0, 1'b0},
    '{2'h0, 2'h0, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0}
  };

  // Free-running 125 MHz clock.
  always #4 clock = ~clock;

  hb_controller_model ctl_u (.powerUp(suppliesGood), .wantModeBottom(wModeB), .wantModeTop(wModeT),
    .wantCmdBottom(wCmdB), .wantCmdTop(wCmdT), .modeBottom(modeBottom), .modeTop(modeTop),
    .cmdBottom(cmdB), .cmdTop(cmdT));

  half_bridge_driver_ctrl dut_u (.clock(clock), .rst_b(rst_b), .suppliesGood(suppliesGood),
    .modeBottom(modeBottom), .modeTop(modeTop), .gate_cmd_bottom(cmdB), .gate_cmd_top(cmdT),
    .senseBottom(senseBottom), .senseTop(senseTop), .gateBottom(gateBottom), .gateTop(gateTop),
    .convRunBottom(convRunBottom), .convRunTop(convRunTop), .dischargeBottom(dischargeBottom),
    .dischargeTop(dischargeTop), .operating(operating), .diagBottom(diagBottom), .diagTop(diagTop));

  task automatic check_bit(input logic exp, input logic act);
    num_checks++;
    if (act !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask : check_bit

  task automatic check_word(input logic [28:0] exp, input logic [28:0] act);
    num_checks++;
    if (act !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask : check_word

  task automatic wrap_up();
    $display("checks=%0d failures=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // Watchdog: the whole sequence, with two start-up delays, needs about 2950 cycles.
  initial begin
    #(20000 * 8);
    n_fail++;
    wrap_up();
  end

  // Main sequence: reset, start-up delay, start-up fault, table of cases, second reset.
  initial begin
    repeat (20) @(negedge clock);
    check_bit(1'b0, gateBottom);
    check_word(hb_ctrl_pkg::DIAG_RESET, diagTop);
    rst_b = 1'b1;
    wCmdB = 1'b1;
    suppliesGood = 1'b1;
    // The bottom command is already high but must be ignored until the delay has run out.
    repeat (1200) @(negedge clock);
    check_bit(1'b0, operating);
    check_bit(1'b0, gateBottom);
    repeat (100) @(negedge clock);
    check_bit(1'b1, operating);
    senseBottom = 4'h1;
    repeat (4) @(negedge clock);
    check_bit(1'b0, convRunBottom);
    check_bit(1'b0, diagBottom[hb_ctrl_pkg::BIT_OVERCURRENT]);
    senseBottom = '0;
    repeat (300) @(negedge clock);
    for (int i = 0; i < $size(rows); i++) begin
      r = rows[i];
      senseBottom = r.sense;
      wModeB = r.modeB;
      wModeT = r.modeT;
      wCmdB = r.cmdB;
      wCmdT = r.cmdT;
      senseTop = r.sense;
      repeat (4) @(negedge clock);
      expd = hb_ctrl_pkg::DIAG_RESET;
      expd[hb_ctrl_pkg::BIT_TEMP1] = ~(r.sense[3] | r.sense[2]);
      expd[hb_ctrl_pkg::BIT_TEMP2] = ~r.sense[2];
      expd[hb_ctrl_pkg::BIT_OVERCURRENT] = ~(r.sense[1] | r.sense[0]);
      expd[hb_ctrl_pkg::BIT_INTERLOCK] = ~r.ilk;
      check_bit(r.gB, gateBottom);
      check_bit(r.gT, gateTop);
      check_bit(r.dis, dischargeBottom);
      check_bit(r.modeT == 2'h1, dischargeTop);
      check_bit(~r.sense[2], convRunBottom);
      check_word(expd, diagBottom);
      check_bit(~r.sense[2], convRunTop);
      check_word(expd, diagTop);
      check_bit(~r.ilk, diagBottom[hb_ctrl_pkg::BIT_INTERLOCK]);
    end
    wCmdB = 1'b1;
    repeat (4) @(negedge clock);
    rst_b = 1'b0;
    @(negedge clock);
    check_bit(1'b0, gateBottom);
    check_bit(1'b0, operating);
    // A second release must run the whole start-up delay again before the command acts.
    rst_b = 1'b1;
    repeat (2) @(negedge clock);
    check_bit(1'b0, operating);
    check_bit(1'b0, gateBottom);
    repeat (1260) @(negedge clock);
    check_bit(1'b1, operating);
    check_bit(1'b1, gateBottom);
    wrap_up();
  end
endmodule : half_bridge_driver_ctrl_test

`default_nettype wire

// ---- verif/hb_controller_model.sv ----
// Behavioural model of the external system controller that drives the mode and gate command pins.
`timescale 1ns/100ps
`default_nettype none

module hb_controller_model (
  input  wire logic                  powerUp,
  input  wire hb_ctrl_pkg::mode_in_t wantModeBottom,
  input  wire hb_ctrl_pkg::mode_in_t wantModeTop,
  input  wire logic                  wantCmdBottom,
  input  wire logic                  wantCmdTop,
  output var  hb_ctrl_pkg::mode_in_t modeBottom,
  output var  hb_ctrl_pkg::mode_in_t modeTop,
  output var  logic                  cmdBottom,
  output var  logic                  cmdTop
);
  // Pins stay low until the supplies are up, so a half-powered driver never sees a stray command.
  always_comb begin
    modeBottom = powerUp ? wantModeBottom : '0;
    modeTop    = powerUp ? wantModeTop : '0;
    cmdBottom  = powerUp & wantCmdBottom;
    cmdTop     = powerUp & wantCmdTop;
  end
endmodule : hb_controller_model

`default_nettype wire
